// *** sensor_result_status_regs.v ***
/*
 Result, status, snapshot and serial number register bank of a digital
 pressure sensor. Assumes the serial interface delivers decoded word
 accesses (address, strobe, data) and ignores frame errors itself; the
 measurement logic delivers results with one-cycle load strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sensor_regs_defines.vh"

// Behaviour
// RULE1: Pressure result read-only at 0x30; each load sets pressure-updated flag.
// RULE2: Temperature result read-only at 0x2E; each load sets temperature-updated flag.
// RULE3: Results hold invalid contents until first measurement is loaded.
// RULE4: When configuration checksum failed, results are never updated.
// RULE5: Host waits for both updated flags before trusting results.
// RULE6: Snapshot bits 15:5 and 0 equal the live status bits.
// RULE7: Snapshot bits 3,4 captured from live flags when results are read.
// RULE8: Burst of three words from 0x2E gives temperature, pressure, snapshot.
// RULE9: Live status bit 0 is 0 when busy, 1 when idle.
// RULE10: Bits 3,4 set on result update, cleared on result read.
// RULE11: Bit 7 set as event on bridge supply fault.
// RULE12: Bit 8 set as event on bridge check fault.
// RULE13: Bit 10 shows saturation of the current result computation.
// RULE14: Bit 11 set as event on serial transfer checksum error.
// RULE15: Bits 14,15 set when a load finds its updated flag still set.
// RULE16: Events stay set until 1 written to live status; snapshot writes ignored.
// RULE17: Writing 0xFFFF to live status clears all event flags.
// RULE18: Condition flags follow present hardware state only.
// RULE19: Serial number low word at 0x50, high word at 0x52, read-only.
// RULE20: Only live status (and command) register accept host writes.
// RULE21: Reserved status bits read zero and ignore writes.
module sensor_result_status_regs #(
	parameter [15:0] SERIAL_LOW = 16'h1234, // Arbitrary value
	parameter [15:0] SERIAL_HIGH = 16'h5678 // Arbitrary value
) (
	input wire MCLK, // System clock, 100 MHz
	input wire RESET, // Asynchronous reset, active high
	input wire [7:0] ADDR, // Word byte address of access
	input wire RD, // Read strobe, one cycle
	input wire WR, // Write strobe, one cycle
	input wire [15:0] WDATA, // Write data
	output reg [15:0] RDATA, // Read data, valid the cycle after RD
	input wire CHECKSUM_FAIL, // Configuration checksum failed, level
	input wire BUSY, // Chip busy, level
	input wire PRESS_LOAD, // New pressure value, one-cycle strobe
	input wire [15:0] PRESS_VALUE, // Corrected pressure
	input wire TEMP_LOAD, // New temperature value, one-cycle strobe
	input wire [15:0] TEMP_VALUE, // Corrected temperature
	input wire SATURATED, // Current result saturated, level
	input wire BRIDGE_SUPPLY_FAULT, // Bridge supply fault, pulse
	input wire BRIDGE_CHECK_FAULT, // Bridge check fault, pulse
	input wire COM_CRC_ERROR // Serial transfer checksum error, pulse
);

	localparam [15:0] status_init = `STATUS_RESET;

	reg [15:0] press_result;
	reg [15:0] temp_result;
	reg snap_press_up;
	reg snap_temp_up;
	reg [15:0] next_rdata;
	wire [15:0] events;
	wire [15:0] live_status;
	wire [15:0] snapshot;
	wire [15:0] wr_clear;
	wire [15:0] rd_clear;
	wire [15:0] clear_events;
	wire [15:0] set_events;
	wire press_load_ok;
	wire temp_load_ok;
	wire rd_press;
	wire rd_temp;
	wire wr_status;
	wire press_up;
	wire temp_up;
	wire supply_fault;
	wire check_fault;
	wire com_crc;
	wire press_missed;
	wire temp_missed;
	wire idle;
	wire saturated;

	// RULE4 gate loads
	assign press_load_ok = PRESS_LOAD & ~CHECKSUM_FAIL;
	assign temp_load_ok = TEMP_LOAD & ~CHECKSUM_FAIL;

	// Decoded accesses
	assign rd_press = RD & (ADDR == `ADDR_PRESS_RESULT);
	assign rd_temp = RD & (ADDR == `ADDR_TEMP_RESULT);
	assign wr_status = WR & (ADDR == `ADDR_EVENT_STATUS);

	// RULE16 RULE17 RULE20 write-one-clear
	assign wr_clear = wr_status ? (WDATA & `EVENT_MASK) : 16'h0000;

	// RULE10 read clears updated flag
	assign rd_clear = {11'h000, rd_temp, rd_press, 3'h0};
	assign clear_events = wr_clear | rd_clear;

	// RULE10 RULE11 RULE12 RULE14 RULE15 event sources
	assign set_events = {
		temp_load_ok & events[`BIT_TEMP_UP],
		press_load_ok & events[`BIT_PRESS_UP],
		2'h0,
		COM_CRC_ERROR,
		2'h0,
		BRIDGE_CHECK_FAULT,
		BRIDGE_SUPPLY_FAULT,
		2'h0,
		temp_load_ok,
		press_load_ok,
		3'h0
	};

	// Stored events gathered at their bit positions
	assign events = {
		temp_missed,
		press_missed,
		2'h0,
		com_crc,
		2'h0,
		check_fault,
		supply_fault,
		2'h0,
		temp_up,
		press_up,
		3'h0
	};

	// RULE9 RULE18 idle follows busy
	assign idle = ~BUSY;

	// RULE13 RULE18 saturation condition
	assign saturated = SATURATED;

	// RULE21 reserved bits read zero
	assign live_status = {events[15:11], saturated, events[9:1], idle};

	// RULE6 mirror live bits
	assign snapshot = (live_status & `LIVE_COPY_MASK) |
		{11'h000, snap_temp_up, snap_press_up, 3'h0};

	// RULE1 RULE10 pressure updated
	status_event_flag #(
		.INIT(status_init[`BIT_PRESS_UP])
	) u_status_event_flag_press_up (
		.mclk(MCLK),
		.reset(RESET),
		.set(set_events[`BIT_PRESS_UP]),
		.clear(clear_events[`BIT_PRESS_UP]),
		.flag(press_up)
	);

	// RULE2 RULE10 temperature updated
	status_event_flag #(
		.INIT(status_init[`BIT_TEMP_UP])
	) u_status_event_flag_temp_up (
		.mclk(MCLK),
		.reset(RESET),
		.set(set_events[`BIT_TEMP_UP]),
		.clear(clear_events[`BIT_TEMP_UP]),
		.flag(temp_up)
	);

	// RULE11 bridge supply fault
	status_event_flag #(
		.INIT(status_init[`BIT_SUPPLY_FAULT])
	) u_status_event_flag_supply (
		.mclk(MCLK),
		.reset(RESET),
		.set(set_events[`BIT_SUPPLY_FAULT]),
		.clear(clear_events[`BIT_SUPPLY_FAULT]),
		.flag(supply_fault)
	);

	// RULE12 bridge check fault
	status_event_flag #(
		.INIT(status_init[`BIT_CHECK_FAULT])
	) u_status_event_flag_check (
		.mclk(MCLK),
		.reset(RESET),
		.set(set_events[`BIT_CHECK_FAULT]),
		.clear(clear_events[`BIT_CHECK_FAULT]),
		.flag(check_fault)
	);

	// RULE14 transfer checksum error
	status_event_flag #(
		.INIT(status_init[`BIT_COM_CRC])
	) u_status_event_flag_com_crc (
		.mclk(MCLK),
		.reset(RESET),
		.set(set_events[`BIT_COM_CRC]),
		.clear(clear_events[`BIT_COM_CRC]),
		.flag(com_crc)
	);

	// RULE15 pressure missed
	status_event_flag #(
		.INIT(status_init[`BIT_PRESS_MISSED])
	) u_status_event_flag_press_missed (
		.mclk(MCLK),
		.reset(RESET),
		.set(set_events[`BIT_PRESS_MISSED]),
		.clear(clear_events[`BIT_PRESS_MISSED]),
		.flag(press_missed)
	);

	// RULE15 temperature missed
	status_event_flag #(
		.INIT(status_init[`BIT_TEMP_MISSED])
	) u_status_event_flag_temp_missed (
		.mclk(MCLK),
		.reset(RESET),
		.set(set_events[`BIT_TEMP_MISSED]),
		.clear(clear_events[`BIT_TEMP_MISSED]),
		.flag(temp_missed)
	);

	// RULE1 RULE2 RULE3 result loads
	always @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
		begin
			press_result <= `RESULT_RESET;
			temp_result <= `RESULT_RESET;
		end
		else
		begin
			if (press_load_ok)
				press_result <= PRESS_VALUE;
			if (temp_load_ok)
				temp_result <= TEMP_VALUE;
		end
	end

	// RULE7 capture on result read
	always @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
		begin
			snap_press_up <= 1'b0;
			snap_temp_up <= 1'b0;
		end
		else
		begin
			if (rd_press)
				snap_press_up <= events[`BIT_PRESS_UP];
			if (rd_temp)
				snap_temp_up <= events[`BIT_TEMP_UP];
		end
	end

	// RULE8 RULE19 read decode
	always @*
	begin
		if (ADDR == `ADDR_TEMP_RESULT)
			next_rdata = temp_result;
		else if (ADDR == `ADDR_PRESS_RESULT)
			next_rdata = press_result;
		else if (ADDR == `ADDR_SNAPSHOT)
			next_rdata = snapshot;
		else if (ADDR == `ADDR_EVENT_STATUS)
			next_rdata = live_status;
		else if (ADDR == `ADDR_SERIAL_LOW)
			next_rdata = SERIAL_LOW;
		else if (ADDR == `ADDR_SERIAL_HIGH)
			next_rdata = SERIAL_HIGH;
		else
			next_rdata = 16'h0000;
	end

	always @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
			RDATA <= 16'h0000;
		else if (RD)
			RDATA <= next_rdata;
	end

endmodule

// One stored event bit; a set wins over a clear in the same cycle
module status_event_flag #(
	parameter [0:0] INIT = 1'h0 // Value after reset
) (
	input wire mclk, // System clock
	input wire reset, // Asynchronous reset, active high
	input wire set, // Event seen this cycle
	input wire clear, // Clear request this cycle
	output reg flag // Stored event
);

	always @(posedge mclk or posedge reset)
	begin
		if (reset)
			flag <= INIT;
		else if (set)
			flag <= 1'h1;
		else if (clear)
			flag <= 1'h0;
	end

endmodule
`default_nettype wire

// *** sensor_regs_defines.vh ***
/*
 Register offsets, flag positions and reset values of the sensor result
 and status register bank. Definitions only; included by the bank.
*/
`ifndef SENSOR_REGS_DEFINES_VH
`define SENSOR_REGS_DEFINES_VH

`define ADDR_TEMP_RESULT 8'h2E
`define ADDR_PRESS_RESULT 8'h30
`define ADDR_SNAPSHOT 8'h32
`define ADDR_EVENT_STATUS 8'h36
`define ADDR_SERIAL_LOW 8'h50
`define ADDR_SERIAL_HIGH 8'h52

`define BIT_IDLE 0
`define BIT_PRESS_UP 3
`define BIT_TEMP_UP 4
`define BIT_SUPPLY_FAULT 7
`define BIT_CHECK_FAULT 8
`define BIT_SATURATED 10
`define BIT_COM_CRC 11
`define BIT_PRESS_MISSED 14
`define BIT_TEMP_MISSED 15

`define EVENT_MASK 16'hC998
`define LIVE_COPY_MASK 16'hCD81
`define STATUS_RESET 16'h0000
`define RESULT_RESET 16'h0000

`endif

// *** status_bank_monitor.sv ***
/* Port assertions of the status bank; bound to every bank instance. */
`timescale 1ns/1ps
`default_nettype none
module status_bank_monitor (
	input wire MCLK, // clk
	input wire RESET, // rst
	input wire [7:0] ADDR, // addr
	input wire RD, // read
	input wire WR, // write
	input wire [15:0] WDATA, // wdata
	input wire [15:0] RDATA, // rdata
	input wire CHECKSUM_FAIL, // block
	input wire BUSY, // busy
	input wire PRESS_LOAD, // load
	input wire [15:0] PRESS_VALUE // value
);
default clocking @(posedge MCLK); endclocking
default disable iff (RESET);
wire s = RD && ADDR == 8'h36;
wire a = ADDR == 8'h30 && !PRESS_LOAD;
wire p = PRESS_LOAD && !CHECKSUM_FAIL;
a_idle_bit: assert property ($stable(BUSY) ##1 s && $stable(BUSY)
	|=> RDATA[0] == !$past(BUSY)) else $error("idle bit");
a_reserved_zero: assert property (RD && (ADDR | 8'h04) == 8'h36
	|=> (RDATA & 16'h3266) == 0) else $error("reserved bit");
a_press_flag: assert property (p ##1 s |=> RDATA[3])
	else $error("update flag");
a_missed_flag: assert property (p ##1 p ##1 s |=> RDATA[14])
	else $error("missed flag");
a_press_value: assert property (p ##1 s && !PRESS_LOAD ##1 RD && a
	|=> RDATA == $past(PRESS_VALUE, 3)) else $error("pressure");
a_read_clear: assert property (RD && a ##1 s && !PRESS_LOAD
	|=> !RDATA[3]) else $error("clear on read");
a_write_ignored: assert property (RD && a ##1 WR && a ##1 RD && a
	|=> $stable(RDATA)) else $error("read only");
a_clear_all: assert property (WR && ADDR == 8'h36
	&& WDATA == 16'hFFFF && !PRESS_LOAD ##1 s |=> (RDATA & 16'h4008) == 0)
	else $error("clear");
endmodule
bind sensor_result_status_regs status_bank_monitor u_status_bank_monitor (.*);
`default_nettype wire

// *** host_bus.sv ***
/* Host access driver; one word per cycle, changed 1 ns after MCLK. */
`timescale 1ns/1ps
`default_nettype none
module host_bus (
	input wire MCLK, // clk
	output logic [7:0] ADDR, // addr
	output logic RD, // read
	output logic WR, // write
	output logic [15:0] WDATA // data
);
initial {ADDR, RD, WR, WDATA} = 0;
task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
begin
	{RD, WR, ADDR, WDATA} = {!w, w, a, d};
	@(posedge MCLK) #1;
end
endtask
task idle;
begin
	{RD, WR} = 0;
	WDATA = ~WDATA;
	@(posedge MCLK) #1;
end
endtask
endmodule
`default_nettype wire

// *** sensor_result_status_regs_tb.sv ***
/* Self-checking bench of the status bank; host_bus drives the port. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin errors++; \
$display("mismatch %0t %h %h", $time, g, x); end end
module sensor_result_status_regs_tb;
logic MCLK = 0, RESET = 1, RD, WR, CHECKSUM_FAIL = 0, BUSY = 0, SATURATED = 0;
logic PRESS_LOAD = 0, TEMP_LOAD = 0, BRIDGE_SUPPLY_FAULT = 0, rd_d = 0;
logic BRIDGE_CHECK_FAULT = 0, COM_CRC_ERROR = 0;
logic [7:0] ADDR;
logic [15:0] PRESS_VALUE = 0, TEMP_VALUE = 0, WDATA, RDATA, p, t, e, q[$];
int errors = 0, cmp_count = 0;
sensor_result_status_regs u_sensor_result_status_regs (.*);
host_bus u_host_bus (.*);
always #5 MCLK = ~MCLK;
always @(posedge MCLK)
begin
	rd_d <= RD;
	if (rd_d)
	begin
		e = q.pop_front();
		`CHK(RDATA, e)
	end
end
task rd(input logic [7:0] a, input logic [15:0] x);
begin
	q.push_back(x);
	u_host_bus.acc(0, a, 0);
end
endtask
task ld(input logic [1:0] m, input int n);
begin
	{PRESS_LOAD, TEMP_LOAD, PRESS_VALUE, TEMP_VALUE} = {m, p, t};
	repeat (n) @(posedge MCLK) #1;
	{PRESS_LOAD, TEMP_LOAD} = 0;
end
endtask
task final_report;
begin
	$display("errors %0d compares %0d", errors, cmp_count);
	if (errors == 0 && cmp_count > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
end
endtask
initial
begin
	#2000;
	errors++;
	final_report;
end
initial
begin
	p = 16'($urandom(83612));
	t = 16'($urandom);
	repeat (6) @(posedge MCLK);
	#1 RESET = 0;
	rd(8'h36, 16'h0001);
	rd(8'h30, 16'h0000);
	u_host_bus.idle;
	ld(2'h3, 1);
	rd(8'h36, 16'h0019);
	rd(8'h2E, t);
	rd(8'h30, p);
	rd(8'h32, 16'h0019);
	rd(8'h36, 16'h0001);
	u_host_bus.idle;
	p = ~p;
	ld(2'h3, 2);
	rd(8'h36, 16'hC019);
	rd(8'h30, p);
	u_host_bus.acc(1, 8'h30, t);
	rd(8'h30, p);
	rd(8'h36, 16'hC011);
	u_host_bus.acc(1, 8'h32, 16'hFFFF);
	u_host_bus.idle;
	{BUSY, SATURATED, BRIDGE_SUPPLY_FAULT} = '1;
	{BRIDGE_CHECK_FAULT, COM_CRC_ERROR} = '1;
	@(posedge MCLK) #1;
	{BRIDGE_SUPPLY_FAULT, BRIDGE_CHECK_FAULT, COM_CRC_ERROR} = 0;
	rd(8'h36, 16'hCD90);
	rd(8'h32, 16'hCD90);
	u_host_bus.acc(1, 8'h36, 16'h0180);
	{BUSY, SATURATED} = 0;
	u_host_bus.idle;
	rd(8'h36, 16'hC811);
	u_host_bus.acc(1, 8'h36, 16'hFFFF);
	rd(8'h36, 16'h0001);
	rd(8'h50, 16'h1234);
	rd(8'h52, 16'h5678);
	CHECKSUM_FAIL = 1;
	u_host_bus.idle;
	p = ~p;
	ld(2'h3, 1);
	rd(8'h36, 16'h0001);
	rd(8'h30, ~p);
	u_host_bus.idle;
	final_report;
end
endmodule
`default_nettype wire
